// [verilog/fldo_consts.vh]
// constants for the feedback link diagnostic outputs block
`ifndef FLDO_CONSTS_VH
`define FLDO_CONSTS_VH
// register word offsets (byte addresses)
`define FLDO_OFF_CTRL      8'h00
`define FLDO_OFF_STAT      8'h04
`define FLDO_OFF_IRQ_STAT  8'h08
`define FLDO_OFF_IRQ_CLR   8'h0C
`define FLDO_OFF_IRQ_EN    8'h10
`define FLDO_OFF_ACC_MAX   8'h14
`define FLDO_OFF_DEV_MAX   8'h18
`define FLDO_OFF_ACC_LIM   8'h1C
`define FLDO_OFF_TALLY     8'h20
`define FLDO_OFF_DEV_NOW   8'h24
`define FLDO_OFF_RMT_CMD   8'h28
`define FLDO_OFF_RMT_ANS   8'h2C
// remote mirror window, register index 40h..7Fh
`define FLDO_RMT_LO        8'h40
`define FLDO_RMT_HI        8'h7F
// ctrl register fields
`define FLDO_CTRL_STROBE_EN 0
`define FLDO_CTRL_RST_VAL   32'h0000_0001
// status / event bit positions
`define FLDO_EV_EST        0
`define FLDO_EV_DEV        1
`define FLDO_EV_SAFE       2
`define FLDO_EV_STALE      3
`define FLDO_EV_FAST       4
`define FLDO_EV_ACCLIM     5
`define FLDO_EV_LINE       6
`define FLDO_EV_RMT        7
`define FLDO_NEV           8
// frame layout of sample strobes
`define FLDO_CH1_BITS      50
`define FLDO_CH2_BITS      10
// strobe offset from line driver, ns, and clock period, ns
`define FLDO_STROBE_OFS_NS 40
`define FLDO_CLK_NS        25
// least time rounds up
`define FLDO_STROBE_OFS_CYC ((`FLDO_STROBE_OFS_NS + `FLDO_CLK_NS - 1) / `FLDO_CLK_NS)
`endif

// [verilog/fldo_strobe.v]
// bit sampling strobe generator: delayed pulse per received bit, frame pattern 50 + pause + 10
`timescale 1ns/10ps
`include "fldo_consts.vh"
module fldo_strobe #(
	parameter DLY = `FLDO_STROBE_OFS_CYC
)(
	// clock, reset, enable
	input  wire clk_i,
	input  wire rst_i,
	input  wire ce_i,
	// control
	input  wire enable_i,
	input  wire frame_start_i,
	input  wire bit_sample_i,
	// strobe and count
	output reg  strobe_o,
	output reg  [5:0] bit_cnt_o
);
	// delay line places edge a fixed offset after the sampling point
	reg [DLY-1:0] dly_reg;
	reg           ch2_reg;
	wire          gate;
	wire [DLY:0]  dly_shift;

	// pause bit gated out
	// only bits 1..50 of channel 1 and 1..10 of channel 2 pass; the pause bit must not pulse
	assign gate = bit_sample_i && enable_i &&
		(ch2_reg ? (bit_cnt_o < 6'd`FLDO_CH2_BITS) : (bit_cnt_o < 6'd`FLDO_CH1_BITS));

	// new bit enters at the bottom; one form serves any delay of one cycle or more
	assign dly_shift = {dly_reg, gate && !frame_start_i};

	// pattern counter; the pause bit between channels yields no pulse
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			dly_reg   <= {DLY{1'b0}};
			strobe_o  <= 1'b0;
			bit_cnt_o <= 6'h00;
			ch2_reg   <= 1'b0;
		end
		else if (ce_i)
		begin
			strobe_o <= dly_reg[DLY-1];
			dly_reg  <= dly_shift[DLY-1:0];
			if (frame_start_i)
			begin
				bit_cnt_o <= 6'h00;
				ch2_reg   <= 1'b0;
			end
			else if (bit_sample_i && !ch2_reg && bit_cnt_o == 6'd`FLDO_CH1_BITS)
			begin
				// pause bit: switch to channel 2
				ch2_reg   <= 1'b1;
				bit_cnt_o <= 6'h00;
			end
			else if (gate)
				bit_cnt_o <= bit_cnt_o + 6'h01;
		end
	end
endmodule

// [verilog/fldo_top.v]
// diagnostic outputs of the encoder link master with a wishbone register slave
// Notes on behaviour
// - strobe per bit: 50, pause, 10
// - strobe edge offset 40 ns
// - estimator output while fast position invalid
// - five events invalidate fast position
// - estimate from two latest safe positions
// - worst deviation from max acceleration
// - deviation flag when above tolerable maximum
// - safe fault on safe coding/checksum error
// - stale safe: not updated, never written, error
// - fast code fault after fast transmission
// - tally counts while fault, clears after
// - tally limit flag above threshold
// - line-code fault on disturbed 8b/10b
// - remote registers mirrored at 40h-7Fh
// - bit access codes; unimplemented read zero
// - reset values forced on reset
// - write-only and unused addresses read zero
// - all registers reachable over host bus
//
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/10ps
`include "fldo_consts.vh"
module fldo_top #(
	parameter PW = 24,
	parameter TW = 8
)(
	// clock, reset, enable
	input  wire          clk_i,
	input  wire          rst_i,
	input  wire          ce_i,
	// wishbone slave
	input  wire          cyc_i,
	input  wire          stb_i,
	input  wire          we_i,
	input  wire [7:0]    adr_i,
	input  wire [3:0]    sel_i,
	input  wire [31:0]   dat_i,
	output reg  [31:0]   dat_o,
	output reg           ack_o,
	// link receiver events
	input  wire          frame_start_i,
	input  wire          bit_sample_i,
	input  wire          fast_tx_i,
	input  wire          fast_code_err_i,
	input  wire          fast_crc_err_i,
	input  wire          enc_pos_err_i,
	input  wire          realign_i,
	input  wire          resync_i,
	input  wire          safe_tx_i,
	input  wire          safe_code_err_i,
	input  wire          safe_crc_err_i,
	input  wire [PW-1:0] safe_pos_i,
	input  wire          line_code_err_i,
	// remote register transport
	output reg           rmt_req_o,
	output reg  [5:0]    rmt_adr_o,
	output reg           rmt_we_o,
	output reg  [7:0]    rmt_wdat_o,
	input  wire          rmt_ans_i,
	input  wire [7:0]    rmt_ans_dat_i,
	// diagnostic outputs
	output reg           sample_o,
	output reg           estimator_on_o,
	output reg           dev_thr_err_o,
	output reg           safe_channel_err_o,
	output reg           safe_pos_err_o,
	output reg           fast_code_err_o,
	output reg           acc_thr_err_o,
	output reg           encoding_err_o,
	output reg  [PW-1:0] est_pos_o,
	output reg           irq_o
);
	// registers
	reg  [31:0]   ctrl_reg;
	reg  [PW-1:0] acc_max_reg;
	reg  [PW-1:0] dev_max_reg;
	reg  [TW-1:0] acc_lim_reg;
	reg  [TW-1:0] tally_reg;
	reg  [`FLDO_NEV-1:0] ev_reg;
	reg  [`FLDO_NEV-1:0] ev_next;
	reg  [`FLDO_NEV-1:0] en_reg;
	reg  [PW-1:0] pos_a_reg;
	reg  [PW-1:0] pos_b_reg;
	reg  [1:0]    valid_cnt_reg;
	reg  [PW-1:0] est_dev_reg;
	reg  [PW-1:0] elapsed_reg;
	reg           safe_seen_reg;
	reg           fast_bad_reg;
	reg  [7:0]    rmt_ans_reg;
	reg           rmt_rdy_reg;
	reg  [31:0]   rd_next;
	wire          strobe;
	wire          wr_acc;
	wire          rd_acc;
	wire          fast_inv;
	wire [`FLDO_NEV-1:0] ev_now;
	wire [31:0]   acc_max_m;
	wire [31:0]   dev_max_m;
	wire [31:0]   acc_lim_m;

	// apply byte enables to an old word
	function [31:0] fldo_merge;
		input [31:0] old;
		input [31:0] wd;
		input [3:0]  sel;
		integer      i;
		begin
			fldo_merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (sel[i])
					fldo_merge[i*8 +: 8] = wd[i*8 +: 8];
		end
	endfunction

	// saturating add keeps the deviation from wrapping to a small value
	function [PW-1:0] fldo_sadd;
		input [PW-1:0] a;
		input [PW-1:0] b;
		reg   [PW:0]   s;
		begin
			s = {1'b0, a} + {1'b0, b};
			fldo_sadd = s[PW] ? {PW{1'b1}} : s[PW-1:0];
		end
	endfunction

	// the remote mirror window is decoded for reads and for forwarding alike
	function fldo_in_rmt;
		input [7:0] ad;
		begin
			fldo_in_rmt = (ad >= `FLDO_RMT_LO) && (ad <= `FLDO_RMT_HI);
		end
	endfunction

	// byte-lane merge of a write; only the low bits of each merged word are kept
	assign acc_max_m = fldo_merge({{(32-PW){1'b0}}, acc_max_reg}, dat_i, sel_i);
	assign dev_max_m = fldo_merge({{(32-PW){1'b0}}, dev_max_reg}, dat_i, sel_i);
	assign acc_lim_m = fldo_merge({{(32-TW){1'b0}}, acc_lim_reg}, dat_i, sel_i);

	fldo_strobe #(
		.DLY (`FLDO_STROBE_OFS_CYC)
	) u_strobe (
		.clk_i         (clk_i),
		.rst_i         (rst_i),
		.ce_i          (ce_i),
		.enable_i      (ctrl_reg[`FLDO_CTRL_STROBE_EN]),
		.frame_start_i (frame_start_i),
		.bit_sample_i  (bit_sample_i),
		.strobe_o      (strobe),
		.bit_cnt_o     ()
	);

	// one access per request; ack drops the cycle after it rose
	assign wr_acc = cyc_i && stb_i && !ack_o && we_i;
	assign rd_acc = cyc_i && stb_i && !ack_o && !we_i;

	assign fast_inv = enc_pos_err_i || fast_code_err_i || fast_crc_err_i || realign_i || resync_i;

	// level events feeding the sticky status bits
	assign ev_now = {rmt_ans_i, line_code_err_i, (tally_reg > acc_lim_reg), fast_code_err_o,
		safe_pos_err_o, safe_channel_err_o, dev_thr_err_o, estimator_on_o};

	always @*
	begin
		rd_next = 32'h0000_0000;
		if (fldo_in_rmt(adr_i))
			rd_next = 32'h0000_0000;
		else
			case (adr_i)
				`FLDO_OFF_CTRL:     rd_next = ctrl_reg;
				`FLDO_OFF_STAT:     rd_next = {24'h00_0000, ev_now};
				`FLDO_OFF_IRQ_STAT: rd_next = {24'h00_0000, ev_reg};
				`FLDO_OFF_IRQ_EN:   rd_next = {24'h00_0000, en_reg};
				`FLDO_OFF_ACC_MAX:  rd_next = {{(32-PW){1'b0}}, acc_max_reg};
				`FLDO_OFF_DEV_MAX:  rd_next = {{(32-PW){1'b0}}, dev_max_reg};
				`FLDO_OFF_ACC_LIM:  rd_next = {{(32-TW){1'b0}}, acc_lim_reg};
				`FLDO_OFF_TALLY:    rd_next = {{(32-TW){1'b0}}, tally_reg};
				`FLDO_OFF_DEV_NOW:  rd_next = {{(32-PW){1'b0}}, est_dev_reg};
				`FLDO_OFF_RMT_ANS:  rd_next = {23'h00_0000, rmt_rdy_reg, rmt_ans_reg};
				default:            rd_next = 32'h0000_0000;
			endcase
	end

	// sticky events: a set in the same cycle as a clear wins
	always @*
	begin
		ev_next = ev_reg;
		if (wr_acc && adr_i == `FLDO_OFF_IRQ_CLR && sel_i[0])
			ev_next = ev_next & ~dat_i[`FLDO_NEV-1:0];
		ev_next = ev_next | ev_now;
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o       <= 1'b0;
			dat_o       <= 32'h0000_0000;
			ctrl_reg    <= `FLDO_CTRL_RST_VAL;
			acc_max_reg <= {PW{1'b0}};
			dev_max_reg <= {PW{1'b1}};
			acc_lim_reg <= {TW{1'b1}};
			en_reg      <= {`FLDO_NEV{1'b0}};
			ev_reg      <= {`FLDO_NEV{1'b0}};
			irq_o       <= 1'b0;
			rmt_req_o   <= 1'b0;
			rmt_adr_o   <= 6'h00;
			rmt_we_o    <= 1'b0;
			rmt_wdat_o  <= 8'h00;
			rmt_ans_reg <= 8'h00;
			rmt_rdy_reg <= 1'b0;
		end
		else if (ce_i)
		begin
			ack_o     <= cyc_i && stb_i && !ack_o;
			dat_o     <= rd_acc ? rd_next : 32'h0000_0000;
			ev_reg    <= ev_next;
			irq_o     <= |(ev_next & en_reg);
			rmt_req_o <= 1'b0;
			// remote mirror: forwarded, answer fetched later
			if (rmt_ans_i)
			begin
				rmt_ans_reg <= rmt_ans_dat_i;
				rmt_rdy_reg <= 1'b1;
			end
			if (cyc_i && stb_i && !ack_o && fldo_in_rmt(adr_i))
			begin
				rmt_req_o   <= 1'b1;
				rmt_adr_o   <= adr_i[5:0];
				rmt_we_o    <= we_i;
				rmt_wdat_o  <= dat_i[7:0];
				rmt_rdy_reg <= 1'b0;
			end
			if (wr_acc)
				case (adr_i)
					`FLDO_OFF_CTRL:    ctrl_reg    <= fldo_merge(ctrl_reg, dat_i, sel_i) & 32'h0000_0001;
					`FLDO_OFF_IRQ_EN:  en_reg      <= sel_i[0] ? dat_i[`FLDO_NEV-1:0] : en_reg;
					`FLDO_OFF_ACC_MAX: acc_max_reg <= acc_max_m[PW-1:0];
					`FLDO_OFF_DEV_MAX: dev_max_reg <= dev_max_m[PW-1:0];
					`FLDO_OFF_ACC_LIM: acc_lim_reg <= acc_lim_m[TW-1:0];
					default:           ;
				endcase
		end
	end

	// safe channel history and estimator
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pos_a_reg     <= {PW{1'b0}};
			pos_b_reg     <= {PW{1'b0}};
			valid_cnt_reg <= 2'h0;
			safe_seen_reg <= 1'b0;
			elapsed_reg   <= {PW{1'b0}};
			est_dev_reg   <= {PW{1'b0}};
			est_pos_o     <= {PW{1'b0}};
			fast_bad_reg  <= 1'b0;
		end
		else if (ce_i)
		begin
			// keep two latest valid safe positions
			if (safe_tx_i && !safe_code_err_i && !safe_crc_err_i)
			begin
				pos_b_reg     <= pos_a_reg;
				pos_a_reg     <= safe_pos_i;
				safe_seen_reg <= 1'b1;
				if (valid_cnt_reg != 2'h2)
					valid_cnt_reg <= valid_cnt_reg + 2'h1;
			end
			// invalid fast position latched until next good one
			if (fast_tx_i)
				fast_bad_reg <= fast_inv;
			else if (fast_inv)
				fast_bad_reg <= 1'b1;
			// linear extrapolation once per fast transmission while estimating
			if (fast_tx_i && fast_inv && valid_cnt_reg == 2'h2)
			begin
				est_pos_o   <= est_pos_o + (pos_a_reg - pos_b_reg);
				elapsed_reg <= fldo_sadd(elapsed_reg, {{(PW-1){1'b0}}, 1'b1});
				// deviation grows by accumulated acceleration bound
				est_dev_reg <= fldo_sadd(est_dev_reg, fldo_sadd(acc_max_reg, elapsed_reg[PW-1:0] & acc_max_reg));
			end
			else if (fast_tx_i && !fast_inv)
			begin
				est_pos_o   <= pos_a_reg;
				elapsed_reg <= {PW{1'b0}};
				est_dev_reg <= {PW{1'b0}};
			end
		end
	end

	// diagnostic flags and fault tally, all registered
	// synchronous, low in reset
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sample_o           <= 1'b0;
			estimator_on_o     <= 1'b0;
			dev_thr_err_o      <= 1'b0;
			safe_channel_err_o <= 1'b0;
			safe_pos_err_o     <= 1'b0;
			fast_code_err_o    <= 1'b0;
			acc_thr_err_o      <= 1'b0;
			encoding_err_o     <= 1'b0;
			tally_reg          <= {TW{1'b0}};
		end
		else if (ce_i)
		begin
			sample_o       <= strobe;
			estimator_on_o <= fast_bad_reg || fast_inv;
			dev_thr_err_o  <= (est_dev_reg > dev_max_reg);
			if (safe_tx_i)
				safe_channel_err_o <= safe_code_err_i || safe_crc_err_i;
			safe_pos_err_o <= !safe_seen_reg || enc_pos_err_i ||
				(safe_tx_i && (safe_code_err_i || safe_crc_err_i));
			if (fast_tx_i)
				fast_code_err_o <= fast_code_err_i;
			if (!fast_code_err_o)
				tally_reg <= {TW{1'b0}};
			else if (fast_tx_i && tally_reg != {TW{1'b1}})
				tally_reg <= tally_reg + {{(TW-1){1'b0}}, 1'b1};
			acc_thr_err_o  <= (tally_reg > acc_lim_reg);
			encoding_err_o <= line_code_err_i;
		end
	end
endmodule

// [testbench/fldo_top_sva.sv]
// concurrent checks on the ports of the diagnostic outputs block
`timescale 1ns/10ps
module fldo_top_sva (
	// clock, reset and bus
	input logic        clk_i,
	input logic        rst_i,
	input logic        cyc_i,
	input logic        stb_i,
	input logic [7:0]  adr_i,
	input logic [31:0] dat_o,
	input logic        ack_o,
	// remote transport
	input logic        rmt_req_o,
	input logic [5:0]  rmt_adr_o,
	// link events
	input logic        bit_sample_i,
	input logic        enc_pos_err_i,
	input logic        realign_i,
	input logic        resync_i,
	input logic        fast_tx_i,
	input logic        fast_code_err_i,
	input logic        fast_crc_err_i,
	input logic        safe_tx_i,
	input logic        safe_code_err_i,
	input logic        safe_crc_err_i,
	input logic        line_code_err_i,
	// diagnostics
	input logic        sample_o,
	input logic        estimator_on_o,
	input logic        safe_channel_err_o,
	input logic        fast_code_err_o,
	input logic        acc_thr_err_o,
	input logic        encoding_err_o,
	input logic        irq_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// one single-cycle answer per request
	a_ack_single: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
		else $error("bus answer not a single pulse");
	a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
		else $error("read data not zero outside answer");
	a_rmt_forward: assert property (cyc_i && stb_i && !ack_o && adr_i[7:6] == 2'h1 |=>
		rmt_req_o && rmt_adr_o == $past(adr_i[5:0])) else $error("remote access not forwarded");
	// strobe trails its bit by the fixed offset
	a_strobe_offset: assert property ($rose(sample_o) |-> $past(bit_sample_i, 4))
		else $error("strobe offset wrong");
	a_est_follow: assert property (enc_pos_err_i || realign_i || resync_i |=> estimator_on_o)
		else $error("estimator flag missing");
	a_safe_fault: assert property (safe_tx_i && (safe_code_err_i || safe_crc_err_i) |=> safe_channel_err_o)
		else $error("safe fault missing");
	a_fast_fault: assert property (fast_tx_i && !fast_crc_err_i |=> fast_code_err_o == $past(fast_code_err_i))
		else $error("fast code fault wrong");
	a_line_fault: assert property (line_code_err_i |=> encoding_err_o)
		else $error("line code fault missing");
	// reset must quiet the answer, strobe, request, interrupt and five diagnostic flags whatever the inputs do
	a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !(ack_o || sample_o || estimator_on_o || irq_o
		|| safe_channel_err_o || fast_code_err_o || acc_thr_err_o || encoding_err_o || rmt_req_o))
		else $error("output active in reset");
	c_strobe: cover property (sample_o);
	c_irq: cover property (irq_o);
	c_tally: cover property (acc_thr_err_o);
	c_remote: cover property (rmt_req_o);
endmodule
bind fldo_top fldo_top_sva u_sva (
	.clk_i, .rst_i, .cyc_i, .stb_i, .adr_i, .dat_o, .ack_o, .rmt_req_o, .rmt_adr_o, .bit_sample_i,
	.enc_pos_err_i, .realign_i, .resync_i, .fast_tx_i, .fast_code_err_i, .fast_crc_err_i, .safe_tx_i,
	.safe_code_err_i, .safe_crc_err_i, .line_code_err_i, .sample_o, .estimator_on_o, .safe_channel_err_o,
	.fast_code_err_o, .acc_thr_err_o, .encoding_err_o, .irq_o
);

// [testbench/fldo_enc_model.sv]
// behavioural encoder at the far end of the serial link
`timescale 1ns/10ps
module fldo_enc_model (
	// clock and remote requests
	input  logic        clk_i,
	input  logic        req_i,
	input  logic [5:0]  adr_i,
	// answers and link events
	output logic        ans_o,
	output logic [7:0]  ans_dat_o,
	output logic        frame_o,
	output logic        bit_o,
	output logic        fast_o,
	output logic        fcode_o,
	output logic        fcrc_o,
	output logic        perr_o,
	output logic        realign_o,
	output logic        resync_o,
	output logic        safe_o,
	output logic        scode_o,
	output logic        scrc_o,
	output logic [23:0] spos_o,
	output logic        line_o
);
	int         lat = 1;
	int         cnt = 0;
	logic [5:0] a;
	initial
	begin
		{ans_o, ans_dat_o, frame_o, bit_o, perr_o, realign_o, resync_o, spos_o} = 0;
		{fast_o, fcode_o, fcrc_o, safe_o, scode_o, scrc_o, line_o} = 7'h0;
	end
	// bits three cycles apart so each delayed strobe stays distinct
	task frame(input int n);
		@(posedge clk_i);
		frame_o <= 1'b1;
		@(posedge clk_i);
		frame_o <= 1'b0;
		repeat (n)
		begin
			bit_o <= 1'b1;
			@(posedge clk_i);
			bit_o <= 1'b0;
			repeat (2) @(posedge clk_i);
		end
		repeat (8) @(posedge clk_i);
		#1;
	endtask
	// one transmission with its qualifiers; position line toggles once released
	task ev(input logic [6:0] v, input logic [23:0] p);
		@(posedge clk_i);
		{fast_o, fcode_o, fcrc_o, safe_o, scode_o, scrc_o, line_o} <= v;
		spos_o <= p;
		@(posedge clk_i);
		{fast_o, fcode_o, fcrc_o, safe_o, scode_o, scrc_o, line_o} <= 7'h0;
		spos_o <= ~p;
		repeat (2) @(posedge clk_i);
		#1;
	endtask
	// position error, realignment and resync levels
	task inv(input logic [2:0] v);
		@(posedge clk_i);
		{perr_o, realign_o, resync_o} <= v;
		repeat (3) @(posedge clk_i);
		#1;
	endtask
	// delayed remote answer; the data line never rests on a stale value
	always @(posedge clk_i)
	begin
		ans_o <= !req_i && cnt == 1;
		ans_dat_o <= (!req_i && cnt == 1) ? {2'h2, a} : ~ans_dat_o;
		if (req_i)
		begin
			cnt <= lat;
			a <= adr_i;
		end
		else if (cnt != 0)
			cnt <= cnt - 1;
	end
endmodule

// [testbench/feedback_link_diag_outputs_test.sv]
// self-checking bench for the diagnostic outputs block
`timescale 1ns/10ps
`include "fldo_consts.vh"
module feedback_link_diag_outputs_test;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, ce_i;
	logic [3:0]  sel_i;
	logic [7:0]  adr_i, a;
	logic [31:0] dat_i, v;
	logic [63:0] ent;
	logic [63:0] exp_q[$];
	wire  [31:0] dat_o;
	wire  [23:0] safe_pos_i, est_pos_o;
	wire  [7:0]  rmt_ans_dat_i, rmt_wdat_o;
	wire  [5:0]  rmt_adr_o;
	wire         ack_o, rmt_req_o, rmt_ans_i, frame_start_i, bit_sample_i, fast_tx_i, fast_code_err_i, fast_crc_err_i;
	wire         enc_pos_err_i, realign_i, resync_i, safe_tx_i, safe_code_err_i, safe_crc_err_i, line_code_err_i;
	wire         sample_o, estimator_on_o, dev_thr_err_o, safe_channel_err_o, safe_pos_err_o, fast_code_err_o;
	wire         acc_thr_err_o, encoding_err_o, irq_o, rmt_we_o;
	int          miscompares, n_tests, n_samp, seed, i, j;
	int          nb[3] = '{62, 30, 5};
	int          ne[3] = '{60, 30, 0};
	// device under test and the far-end encoder
	fldo_top u_dut (
		.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
		.frame_start_i, .bit_sample_i, .fast_tx_i, .fast_code_err_i, .fast_crc_err_i, .enc_pos_err_i, .realign_i,
		.resync_i, .safe_tx_i, .safe_code_err_i, .safe_crc_err_i, .safe_pos_i, .line_code_err_i, .rmt_req_o,
		.rmt_adr_o, .rmt_we_o, .rmt_wdat_o, .rmt_ans_i, .rmt_ans_dat_i, .sample_o, .estimator_on_o,
		.dev_thr_err_o, .safe_channel_err_o, .safe_pos_err_o, .fast_code_err_o, .acc_thr_err_o, .encoding_err_o,
		.est_pos_o, .irq_o
	);
	fldo_enc_model u_enc (
		.clk_i, .req_i(rmt_req_o), .adr_i(rmt_adr_o), .ans_o(rmt_ans_i), .ans_dat_o(rmt_ans_dat_i),
		.frame_o(frame_start_i), .bit_o(bit_sample_i), .fast_o(fast_tx_i), .fcode_o(fast_code_err_i),
		.fcrc_o(fast_crc_err_i), .perr_o(enc_pos_err_i), .realign_o(realign_i), .resync_o(resync_i),
		.safe_o(safe_tx_i), .scode_o(safe_code_err_i), .scrc_o(safe_crc_err_i), .spos_o(safe_pos_i),
		.line_o(line_code_err_i)
	);
	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	task end_sim;
		if (miscompares == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task timeout;
		miscompares++;
		end_sim;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			miscompares++;
			$display("ERROR %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// classic cycle held until ack; the expected read is noted first
	task wb(input logic w, input logic [7:0] ad, input logic [31:0] d, m, e);
		exp_q.push_back({m, e});
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, ad, d};
		j = 0;
		do
		begin
			@(posedge clk_i);
			j++;
		end
		while (ack_o !== 1'b1 && j < 20);
		{cyc_i, stb_i, we_i} <= 3'h0;
		if (ack_o !== 1'b1)
			timeout;
	endtask
	task rd(input logic [7:0] ad, input logic [31:0] m, e);
		wb(1'b0, ad, 32'h0, m, e);
	endtask
	task wr(input logic [7:0] ad, input logic [31:0] d);
		wb(1'b1, ad, d, 32'hFFFFFFFF, 32'h0);
	endtask
	task w(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// answer watcher: oldest note against each acknowledged read or write; strobe counter
	always @(posedge clk_i)
	begin
		if (sample_o === 1'b1)
			n_samp++;
		if (ack_o === 1'b1)
		begin
			ent = exp_q.pop_front();
			chk(dat_o & ent[63:32], ent[31:0]);
		end
	end
	initial
	begin
		repeat (20000) @(posedge clk_i);
		timeout;
	end
	initial
	begin
		{cyc_i, stb_i, we_i, adr_i, dat_i} = 0;
		ce_i = 1'b1;
		sel_i = 4'hF;
		miscompares = 0;
		n_tests = 0;
		n_samp = 0;
		seed = 23467;
		rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`FLDO_OFF_CTRL, 32'hFFFFFFFF, `FLDO_CTRL_RST_VAL);
		rd(`FLDO_OFF_ACC_LIM, 32'hFF, 32'hFF);
		rd(`FLDO_OFF_IRQ_EN, 32'hFFFFFFFF, 32'h0);
		rd(`FLDO_OFF_IRQ_CLR, 32'hFFFFFFFF, 32'h0);
		rd(8'h3C, 32'hFFFFFFFF, 32'h0);
		w(1);
		chk(safe_pos_err_o, 1);
		v = $random(seed);
		wr(`FLDO_OFF_ACC_LIM, v);
		rd(`FLDO_OFF_ACC_LIM, 32'hFF, v & 32'hFF);
		// a write without byte lane 0 leaves the 8-bit limit alone
		sel_i <= 4'hE;
		wr(`FLDO_OFF_ACC_LIM, ~v);
		sel_i <= 4'hF;
		rd(`FLDO_OFF_ACC_LIM, 32'hFF, v & 32'hFF);
		// strobe frames: full with an overrun bit, partial, disabled
		for (i = 0; i < 3; i++)
		begin
			wr(`FLDO_OFF_CTRL, {31'h0, i != 2});
			n_samp = 0;
			u_enc.frame(nb[i]);
			chk(n_samp, ne[i]);
		end
		for (i = 0; i < 3; i++)
		begin
			u_enc.inv(3'h4 >> i);
			chk(estimator_on_o, 1);
		end
		u_enc.inv(3'h0);
		for (i = 0; i < 2; i++)
		begin
			u_enc.ev(i ? 7'h60 : 7'h50, 24'h0);
			chk(estimator_on_o, 1);
		end
		u_enc.ev(7'h40, 24'h0);
		// deviation grows while estimating and clears on a valid position
		v = $random(seed);
		u_enc.ev(7'h08, ~v[23:0]);
		u_enc.ev(7'h08, v[23:0]);
		wr(`FLDO_OFF_DEV_MAX, 32'h0);
		wr(`FLDO_OFF_ACC_MAX, 32'h10);
		u_enc.inv(3'h2);
		u_enc.ev(7'h40, 24'h0);
		u_enc.ev(7'h40, 24'h0);
		chk(dev_thr_err_o, 1);
		u_enc.inv(3'h0);
		u_enc.ev(7'h40, 24'h0);
		w(2);
		chk(dev_thr_err_o, 0);
		chk(est_pos_o, {8'h00, v[23:0]});
		wr(`FLDO_OFF_ACC_LIM, 32'h2);
		repeat (4) u_enc.ev(7'h60, 24'h0);
		chk(fast_code_err_o, 1);
		rd(`FLDO_OFF_TALLY, 32'hFF, 32'h3);
		w(2);
		chk(acc_thr_err_o, 1);
		u_enc.ev(7'h40, 24'h0);
		rd(`FLDO_OFF_TALLY, 32'hFF, 32'h0);
		w(2);
		chk(acc_thr_err_o, 0);
		for (i = 0; i < 2; i++)
		begin
			u_enc.ev(i ? 7'h0A : 7'h0C, $random(seed));
			chk(safe_channel_err_o, 1);
		end
		u_enc.ev(7'h08, $random(seed));
		chk(safe_channel_err_o, 0);
		chk(safe_pos_err_o, 0);
		u_enc.inv(3'h4);
		chk(safe_pos_err_o, 1);
		// a low clock enable freezes the stale flag although its cause has gone
		@(posedge clk_i);
		ce_i <= 1'b0;
		u_enc.inv(3'h0);
		chk(safe_pos_err_o, 1);
		@(posedge clk_i);
		ce_i <= 1'b1;
		w(2);
		chk(safe_pos_err_o, 0);
		// line fault raises, masks and clears the interrupt
		wr(`FLDO_OFF_IRQ_EN, 32'h40);
		u_enc.ev(7'h01, 24'h0);
		w(2);
		chk(irq_o, 1);
		rd(`FLDO_OFF_IRQ_STAT, 32'h40, 32'h40);
		wr(`FLDO_OFF_IRQ_EN, 32'h0);
		w(2);
		chk(irq_o, 0);
		wr(`FLDO_OFF_IRQ_EN, 32'h40);
		w(2);
		chk(irq_o, 1);
		wr(`FLDO_OFF_IRQ_CLR, 32'h40);
		w(2);
		chk(irq_o, 0);
		rd(`FLDO_OFF_IRQ_STAT, 32'h40, 32'h0);
		// remote window with a prompt and a slow encoder
		for (i = 0; i < 2; i++)
		begin
			u_enc.lat = i ? 14 : 1;
			v = $random(seed);
			a = {2'h1, v[13:8]};
			wr(a, v);
			j = 0;
			while (rmt_ans_i !== 1'b1 && j < 40)
			begin
				@(posedge clk_i);
				j++;
			end
			w(2);
			chk(rmt_we_o, 1);
			chk(rmt_wdat_o, v[7:0]);
			rd(`FLDO_OFF_RMT_ANS, 32'h1FF, {23'h0, 1'b1, 2'h2, a[5:0]});
			rd(a, 32'hFFFFFFFF, 32'h0);
			chk(rmt_we_o, 0);
		end
		w(20);
		// reset in mid-run restores the defaults and the startup flags
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`FLDO_OFF_CTRL, 32'hFFFFFFFF, `FLDO_CTRL_RST_VAL);
		chk(est_pos_o, 0);
		chk(safe_pos_err_o, 1);
		end_sim;
	end
endmodule
